// ==== include/pwm_guard_pkg.sv ====
// package: register map, field layout and encodings of the pwm guard block
package pwm_guard_pkg;
	// ------------------------------------------------------------
	// register byte addresses
	// ------------------------------------------------------------
	localparam logic [3:0] addr_shutdown_control = 4'h0;
	localparam logic [3:0] addr_restart_deadband_control = 4'h4;
	localparam logic [3:0] addr_mode_control = 4'h8;
	localparam logic [3:0] addr_status = 4'hC;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int flag_bit = 7;
	localparam int source_lsb = 4;
	localparam int pair_ac_lsb = 2;
	localparam int pair_bd_lsb = 0;
	localparam int restart_bit = 7;
	localparam int deadband_width = 7;
	localparam logic [7:0] shutdown_control_reset = 8'h00;
	localparam logic [7:0] restart_deadband_reset = 8'h00;
	localparam logic [1:0] axi_okay = 2'h0;
	localparam logic [1:0] axi_slverr = 2'h2;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		mode_single, mode_half_bridge, mode_full_forward, mode_full_reverse
	} bridge_mode_type;
	typedef enum {run_normal, run_shut, run_wait_period} run_state_type;
endpackage

// ==== include/pwm_pins_if.sv ====
// interface: modulated pwm levels and per-pin output enables
interface pwm_pins_if;
	logic [3:0] level;
	logic [3:0] enable;
	modport source (output level, output enable);
	modport sink (input level, input enable);
endinterface

// ==== verilog/deadband_edge.sv ====
// dead band delay on the inactive-to-active edge of one output
module deadband_edge #(
	parameter int width = 7
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic tick,
	input wire logic bypass,
	input wire logic [width-1:0] delay,
	input wire logic raw,
	output logic shaped
);
	logic [width-1:0] count;
	logic [width-1:0] next_count;
	logic next_shaped;

	// falling edges pass at once; rising edges wait delay ticks
	always_comb begin
		next_count = count;
		next_shaped = shaped;
		if (bypass) begin
			next_shaped = raw;
			next_count = '0;
		end else if (!raw) begin
			next_shaped = 1'b0;
			next_count = '0;
		end else if (!shaped) begin
			if (count >= delay) begin
				next_shaped = 1'b1;
			end else if (tick) begin
				next_count = count + 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count <= '0;
			shaped <= 1'b0;
		end else begin
			count <= next_count;
			shaped <= next_shaped;
		end
	end

	chk_edge_immediate_off: assert property (@(posedge aclk) disable iff (!aresetn)
		!bypass && !raw |=> !shaped) else $error("active edge not dropped");
	chk_zero_delay_pass: assert property (@(posedge aclk) disable iff (!aresetn)
		!bypass && raw && delay == '0 |=> shaped) else $error("zero delay late");
endmodule

// ==== verilog/pwm_guard.sv ====
// top: auto-shutdown, restart and dead band logic with an axi4-lite slave
module pwm_guard
	import pwm_guard_pkg::*;
#(
	parameter int deadband_width = pwm_guard_pkg::deadband_width
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic pwm_raw,
	input wire logic period_start,
	input wire logic cycle_tick,
	input wire logic sync_tick,
	input wire logic [3:0] pin_enable,
	input wire logic int_pin,
	input wire logic comparator_one,
	input wire logic comparator_two,
	output logic pwm_out_a,
	output logic pwm_out_a_oe,
	output logic pwm_out_b,
	output logic pwm_out_b_oe,
	output logic pwm_out_c,
	output logic pwm_out_c_oe,
	output logic pwm_out_d,
	output logic pwm_out_d_oe
);
	import pwm_guard_pkg::*;

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic shutdown_event_flag;
	logic [2:0] shutdown_source_select;
	logic [1:0] pair_ac_shutdown_state;
	logic [1:0] pair_bd_shutdown_state;
	logic auto_restart_enable;
	logic [deadband_width-1:0] deadband_count;
	bridge_mode_type bridge_mode;
	logic [1:0] output_polarity_select;
	logic comparator_two_sync_enable;
	run_state_type run_state;
	run_state_type next_run_state;

	// ------------------------------------------------------------
	// source synchronisers and comparator-two sync
	// ------------------------------------------------------------
	logic [2:0] int_sync;
	logic [2:0] c1_sync;
	logic [2:0] c2_sync;
	logic int_level;
	logic c1_level;
	logic c2_level;
	logic c2_held;
	logic next_c2_held;
	logic next_int_level;
	logic next_c1_level;
	logic next_c2_level;

	// a level counts once second and third stages agree
	always_comb begin
		next_int_level = (int_sync[1] == int_sync[2]) ? int_sync[2] : int_level;
		next_c1_level = (c1_sync[1] == c1_sync[2]) ? c1_sync[2] : c1_level;
		next_c2_level = (c2_sync[1] == c2_sync[2]) ? c2_sync[2] : c2_level;
		next_c2_held = c2_held;
		if (!comparator_two_sync_enable || sync_tick) begin
			next_c2_held = c2_level;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_sync <= 3'h7;
			c1_sync <= 3'h0;
			c2_sync <= 3'h0;
			int_level <= 1'b1;
			c1_level <= 1'b0;
			c2_level <= 1'b0;
			c2_held <= 1'b0;
		end else begin
			int_sync <= {int_sync[1:0], int_pin};
			c1_sync <= {c1_sync[1:0], comparator_one};
			c2_sync <= {c2_sync[1:0], comparator_two};
			int_level <= next_int_level;
			c1_level <= next_c1_level;
			c2_level <= next_c2_level;
			c2_held <= next_c2_held;
		end
	end

	// ------------------------------------------------------------
	// shutdown condition decode
	// ------------------------------------------------------------
	// shared by the synced flag path and the raw override path
	function automatic logic source_hit(input logic [2:0] sel,
			input logic pin_low, input logic one, input logic two);
		source_hit = (sel[2] & pin_low) | (sel[0] & one) | (sel[1] & two);
	endfunction

	logic condition;
	logic raw_condition;
	assign condition = source_hit(shutdown_source_select, !int_level,
		c1_level, c2_held);
	// comparator two stays on its synced path when timer sync is on
	assign raw_condition = source_hit(shutdown_source_select, !int_pin,
		comparator_one, comparator_two_sync_enable ? c2_held : comparator_two);

	// ------------------------------------------------------------
	// axi4-lite slave
	// ------------------------------------------------------------
	logic aw_full, w_full, next_aw_full, next_w_full;
	logic [3:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic w_strb0, next_w_strb0;
	logic next_bvalid, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic do_write;
	logic fw_set, fw_clear;
	logic next_flag;
	logic [7:0] next_sc;
	logic [7:0] next_rd;
	logic [7:0] next_mc;
	logic [7:0] shutdown_control_view;

	assign s_axi_awready = !aw_full && !s_axi_bvalid;
	assign s_axi_wready = !w_full && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_write = aw_full && w_full && !s_axi_bvalid;
	assign shutdown_control_view = {shutdown_event_flag, shutdown_source_select,
		pair_ac_shutdown_state, pair_bd_shutdown_state};
	assign fw_set = do_write && aw_addr == addr_shutdown_control && w_strb0
		&& w_data[flag_bit];
	assign fw_clear = do_write && aw_addr == addr_shutdown_control && w_strb0
		&& !w_data[flag_bit] && !condition;

	// bus channels and register writes
	always_comb begin
		next_aw_full = aw_full;
		next_w_full = w_full;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb0 = w_strb0;
		next_bvalid = s_axi_bvalid && !s_axi_bready;
		next_bresp = s_axi_bresp;
		next_rvalid = s_axi_rvalid && !s_axi_rready;
		next_rresp = s_axi_rresp;
		next_rdata = s_axi_rdata;
		next_sc = shutdown_control_view;
		next_rd = {auto_restart_enable, deadband_count};
		next_mc = {3'h0, comparator_two_sync_enable, output_polarity_select,
			bridge_mode};
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_full = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_full = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb0 = s_axi_wstrb[0];
		end
		if (do_write) begin
			next_aw_full = 1'b0;
			next_w_full = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = axi_okay;
			case (aw_addr)
				addr_shutdown_control: if (w_strb0) next_sc = w_data[7:0];
				addr_restart_deadband_control: if (w_strb0) next_rd = w_data[7:0];
				addr_mode_control: if (w_strb0) next_mc = w_data[7:0];
				addr_status: next_bresp = axi_okay;
				default: next_bresp = axi_slverr;
			endcase
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp = axi_okay;
			case (s_axi_araddr)
				addr_shutdown_control: next_rdata = {24'h0, shutdown_control_view};
				addr_restart_deadband_control:
					next_rdata = {24'h0, auto_restart_enable, deadband_count};
				addr_mode_control: next_rdata = {24'h0, next_mc};
				addr_status: next_rdata = {28'h0, c2_held, c1_level, !int_level,
					run_state != run_normal};
				default: begin
					next_rdata = 32'h0;
					next_rresp = axi_slverr;
				end
			endcase
		end
	end

	// flag: hardware set wins over any clear
	always_comb begin
		next_flag = shutdown_event_flag;
		if (fw_clear) next_flag = 1'b0;
		if (auto_restart_enable && shutdown_event_flag && !condition)
			next_flag = 1'b0;
		if (condition || fw_set) next_flag = 1'b1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= 4'h0;
			w_data <= 32'h0;
			w_strb0 <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= axi_okay;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= axi_okay;
			s_axi_rdata <= 32'h0;
			shutdown_event_flag <= shutdown_control_reset[flag_bit];
			{shutdown_source_select, pair_ac_shutdown_state,
				pair_bd_shutdown_state} <= shutdown_control_reset[6:0];
			{auto_restart_enable, deadband_count} <= restart_deadband_reset;
			{comparator_two_sync_enable, output_polarity_select} <= 3'h0;
			bridge_mode <= mode_single;
		end else begin
			aw_full <= next_aw_full;
			w_full <= next_w_full;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb0 <= next_w_strb0;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_rvalid <= next_rvalid;
			s_axi_rresp <= next_rresp;
			s_axi_rdata <= next_rdata;
			shutdown_event_flag <= next_flag;
			{shutdown_source_select, pair_ac_shutdown_state,
				pair_bd_shutdown_state} <= next_sc[6:0];
			auto_restart_enable <= next_rd[restart_bit];
			deadband_count <= next_rd[deadband_width-1:0];
			{comparator_two_sync_enable, output_polarity_select} <= next_mc[4:2];
			bridge_mode <= bridge_mode_type'(next_mc[1:0]);
		end
	end

	// ------------------------------------------------------------
	// restart sequencing
	// ------------------------------------------------------------
	// flag cleared and condition gone still waits for a period boundary
	always_comb begin
		case (run_state)
			run_normal: next_run_state = shutdown_event_flag ? run_shut : run_normal;
			run_shut: next_run_state = (!shutdown_event_flag && !condition)
				? run_wait_period : run_shut;
			run_wait_period: begin
				if (shutdown_event_flag) next_run_state = run_shut;
				else if (period_start) next_run_state = run_normal;
				else next_run_state = run_wait_period;
			end
			default: next_run_state = run_shut;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) run_state <= run_normal;
		else run_state <= next_run_state;
	end

	// ------------------------------------------------------------
	// modulation, dead band and override
	// ------------------------------------------------------------
	pwm_pins_if pins();
	logic half;
	logic [1:0] shaped;
	assign half = bridge_mode == mode_half_bridge;

	// a and b in half bridge get the dead band; full bridge bypasses it
	deadband_edge #(.width(deadband_width)) edge_a (.aclk(aclk),
		.aresetn(aresetn), .tick(cycle_tick), .bypass(!half),
		.delay(deadband_count), .raw(pwm_raw), .shaped(shaped[0]));
	deadband_edge #(.width(deadband_width)) edge_b (.aclk(aclk),
		.aresetn(aresetn), .tick(cycle_tick), .bypass(!half),
		.delay(deadband_count), .raw(!pwm_raw), .shaped(shaped[1]));

	// active levels per pin before polarity
	always_comb begin
		case (bridge_mode)
			mode_half_bridge: pins.level = {1'b0, 1'b0, shaped[1], shaped[0]};
			mode_full_forward: pins.level = {pwm_raw, 1'b0, 1'b0, 1'b1};
			mode_full_reverse: pins.level = {1'b0, 1'b1, pwm_raw, 1'b0};
			default: pins.level = {3'h0, pwm_raw};
		endcase
	end
	assign pins.enable = pin_enable;

	// shutdown forced without waiting for the clock
	logic shut_now;
	logic [3:0] drive;
	logic [3:0] oe;
	assign shut_now = raw_condition || shutdown_event_flag
		|| run_state != run_normal;
	generate
		for (genvar i = 0; i < 4; i++) begin : g_pin
			logic [1:0] st;
			logic pol;
			assign st = (i % 2 == 1) ? pair_bd_shutdown_state
				: pair_ac_shutdown_state;
			assign pol = (i % 2 == 1) ? output_polarity_select[1]
				: output_polarity_select[0];
			assign drive[i] = shut_now ? st[0] : pins.level[i] ^ pol;
			assign oe[i] = pins.enable[i] && !(shut_now && st[1]);
		end
	endgenerate
	assign {pwm_out_d, pwm_out_c, pwm_out_b, pwm_out_a} = drive;
	assign {pwm_out_d_oe, pwm_out_c_oe, pwm_out_b_oe, pwm_out_a_oe} = oe;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	chk_flag_on_condition: assert property (@(posedge aclk) disable iff (!aresetn)
		condition |=> shutdown_event_flag) else $error("flag not set");
	chk_write_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
		condition && shutdown_event_flag |=> shutdown_event_flag)
		else $error("flag cleared under condition");
	chk_auto_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		auto_restart_enable && shutdown_event_flag && !condition && !fw_set
		|=> !shutdown_event_flag) else $error("auto restart failed");
	chk_manual_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		!auto_restart_enable && shutdown_event_flag && !fw_clear
		|=> shutdown_event_flag) else $error("flag lost");
	chk_period_restart: assert property (@(posedge aclk) disable iff (!aresetn)
		run_state == run_wait_period && !period_start && !shutdown_event_flag
		|=> run_state == run_wait_period) else $error("mid period restart");
	chk_pin_override: assert property (@(posedge aclk) disable iff (!aresetn)
		shut_now && pair_ac_shutdown_state == 2'b01 |-> pwm_out_a)
		else $error("pair ac not high");
	chk_tristate_bd: assert property (@(posedge aclk) disable iff (!aresetn)
		shut_now && pair_bd_shutdown_state[1] |-> !pwm_out_b_oe && !pwm_out_d_oe)
		else $error("pair bd driven");
	chk_fw_set: assert property (@(posedge aclk) disable iff (!aresetn)
		fw_set |=> shutdown_event_flag ##1 run_state != run_normal)
		else $error("fw set ignored");
	cov_auto_restart: cover property (@(posedge aclk) disable iff (!aresetn)
		auto_restart_enable && $fell(shutdown_event_flag));
	cov_manual_restart: cover property (@(posedge aclk) disable iff (!aresetn)
		fw_clear && shutdown_event_flag);
	cov_resume: cover property (@(posedge aclk) disable iff (!aresetn)
		run_state == run_wait_period && period_start);
endmodule

// ==== verification/bridge_model.sv ====
// far side: bridge gate drivers seen through the pins, with pull resistors
module bridge_model #(
	parameter logic pull = 1'b0
) (
	input wire logic [3:0] drive,
	input wire logic [3:0] drive_oe,
	output logic [3:0] pin
);
	timeunit 1ns;
	timeprecision 100ps;
	// --------------------------------------------------------------
	// pin resolution
	// --------------------------------------------------------------
	// a released pin settles to the pull level, never the last value
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pin[i] = drive_oe[i] ? drive[i] : pull;
		end
	end
endmodule

// ==== verification/pwm_guard_bench.sv ====
// bench for the pwm guard: shutdown, restart and dead band scenarios
module pwm_guard_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import pwm_guard_pkg::*;
	logic aclk = 0, aresetn = 0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic pwm_raw = 0, period_start = 0, cycle_tick = 0, sync_tick = 0;
	logic [3:0] pin_enable = 4'hF, pin, tick_count = 4'h0;
	logic int_pin = 1, comparator_one = 0, comparator_two = 0;
	logic pwm_out_a, pwm_out_b, pwm_out_c, pwm_out_d;
	logic pwm_out_a_oe, pwm_out_b_oe, pwm_out_c_oe, pwm_out_d_oe;
	int errors = 0, checked = 0;
	logic [31:0] rd;
	logic [1:0] resp;
	pwm_guard DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pwm_raw,
		.period_start, .cycle_tick, .sync_tick, .pin_enable, .int_pin,
		.comparator_one, .comparator_two, .pwm_out_a, .pwm_out_a_oe,
		.pwm_out_b, .pwm_out_b_oe, .pwm_out_c, .pwm_out_c_oe,
		.pwm_out_d, .pwm_out_d_oe);
	bridge_model BRIDGE (.drive({pwm_out_d, pwm_out_c, pwm_out_b, pwm_out_a}),
		.drive_oe({pwm_out_d_oe, pwm_out_c_oe, pwm_out_b_oe, pwm_out_a_oe}),
		.pin(pin));
	// --------------------------------------------------------------
	// clock and instruction cycle tick, one tick every four clocks
	// --------------------------------------------------------------
	always #2.5 aclk = ~aclk;
	always @(posedge aclk) begin
		tick_count <= tick_count + 4'h1;
		cycle_tick <= (tick_count[1:0] == 2'h3);
	end
	// --------------------------------------------------------------
	// reporting
	// --------------------------------------------------------------
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
		input string msg);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t %s seen %h want %h", $time, msg, seen, exp);
		end
	endtask
	// --------------------------------------------------------------
	// axi4-lite master; handshakes judged with the values of the edge
	// --------------------------------------------------------------
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		for (int n = 0; n < 60; n++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid && s_axi_bready) begin
				resp = s_axi_bresp;
				s_axi_bready <= 0;
				return;
			end
		end
		errors++;
		give_verdict();
	endtask
	task automatic rdr(input logic [3:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (int n = 0; n < 60; n++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid && s_axi_rready) begin
				rd = s_axi_rdata;
				resp = s_axi_rresp;
				s_axi_rready <= 0;
				return;
			end
		end
		errors++;
		give_verdict();
	endtask
	// one period boundary pulse, then let the run state settle
	task automatic period();
		@(posedge aclk);
		period_start <= 1;
		@(posedge aclk);
		period_start <= 0;
		repeat (2) @(negedge aclk);
	endtask
	// --------------------------------------------------------------
	// scenarios
	// --------------------------------------------------------------
	task automatic t_reset_map();
		rdr(addr_shutdown_control);
		chk(rd, 32'h0, "shutdown reset");
		rdr(addr_restart_deadband_control);
		chk(rd, 32'h0, "restart reset");
		rdr(4'h3);
		chk(resp, axi_slverr, "unmapped resp");
		$display("test reset_map done");
	endtask
	task automatic t_firmware_shut();
		wr(addr_shutdown_control, 32'h84);
		@(negedge aclk);
		chk(pin, 4'h5, "forced pairs");
		rdr(addr_shutdown_control);
		chk(rd, 32'h84, "flag set");
		wr(addr_shutdown_control, 32'h04);
		repeat (3) @(negedge aclk);
		chk(pin[0], 1'b1, "held until period");
		period();
		chk(pin[0], 1'b0, "resumed");
		$display("test firmware_shut done");
	endtask
	task automatic t_pin_shut();
		wr(addr_shutdown_control, 32'h4A);
		@(posedge aclk);
		int_pin <= 0;
		@(negedge aclk);
		chk(pwm_out_a_oe, 1'b0, "async tri-state");
		chk(pwm_out_d_oe, 1'b0, "async tri-state");
		repeat (6) @(negedge aclk);
		rdr(addr_shutdown_control);
		chk(rd, 32'hCA, "pin source flag");
		wr(addr_shutdown_control, 32'h4A);
		rdr(addr_shutdown_control);
		chk(rd, 32'hCA, "clear ignored");
		@(posedge aclk);
		int_pin <= 1;
		repeat (6) @(negedge aclk);
		wr(addr_shutdown_control, 32'h4A);
		rdr(addr_shutdown_control);
		chk(rd, 32'h4A, "clear taken");
		period();
		chk(pwm_out_a_oe, 1'b1, "drive back");
		$display("test pin_shut done");
	endtask
	task automatic t_auto_restart();
		wr(addr_restart_deadband_control, 32'h80);
		wr(addr_shutdown_control, 32'h10);
		@(posedge aclk);
		pwm_raw <= 1;
		comparator_one <= 1;
		repeat (6) @(negedge aclk);
		rdr(addr_shutdown_control);
		chk(rd, 32'h90, "flag while active");
		@(posedge aclk);
		comparator_one <= 0;
		repeat (8) @(negedge aclk);
		rdr(addr_shutdown_control);
		chk(rd, 32'h10, "hardware clear");
		chk(pin[0], 1'b0, "still shut");
		period();
		chk(pin[0], 1'b1, "auto resumed");
		$display("test auto_restart done");
	endtask
	task automatic t_deadband();
		wr(addr_restart_deadband_control, 32'h03);
		wr(addr_mode_control, 32'h1);
		@(posedge aclk);
		pwm_raw <= 0;
		repeat (30) @(negedge aclk);
		chk(pin[1:0], 2'h2, "half low");
		@(posedge aclk);
		pwm_raw <= 1;
		repeat (2) @(negedge aclk);
		chk(pin[1], 1'b0, "b falls at once");
		repeat (4) @(negedge aclk);
		chk(pin[0], 1'b0, "a delayed");
		repeat (14) @(negedge aclk);
		chk(pin[0], 1'b1, "a after delay");
		@(posedge aclk);
		pwm_raw <= 0;
		repeat (2) @(negedge aclk);
		chk(pin[0], 1'b0, "a falls at once");
		$display("test deadband done");
	endtask
	// full forward, a/c polarity inverted, comparator two on timer sync
	task automatic t_c2_full();
		wr(addr_mode_control, 32'h16);
		wr(addr_shutdown_control, 32'h20);
		repeat (2) @(negedge aclk);
		chk(pin, 4'h4, "forward inverted ac");
		@(posedge aclk);
		comparator_two <= 1;
		repeat (8) @(negedge aclk);
		chk(pin, 4'h4, "no sync no shut");
		@(posedge aclk);
		sync_tick <= 1;
		@(posedge aclk);
		sync_tick <= 0;
		repeat (3) @(negedge aclk);
		chk(pin, 4'h0, "shut after tick");
		rdr(addr_shutdown_control);
		chk(rd, 32'hA0, "c2 flag");
		@(posedge aclk);
		comparator_two <= 0;
		repeat (6) @(negedge aclk);
		@(posedge aclk);
		sync_tick <= 1;
		@(posedge aclk);
		sync_tick <= 0;
		repeat (2) @(negedge aclk);
		wr(addr_shutdown_control, 32'h20);
		period();
		chk(pin, 4'h4, "c2 resumed");
		$display("test c2_full done");
	endtask
	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		t_reset_map();
		t_firmware_shut();
		t_pin_shut();
		t_auto_restart();
		t_deadband();
		t_c2_full();
		give_verdict();
	end
endmodule
